// file: core/link_adaptor_pkg.sv
// Shared constants for the serial link to parallel bus adaptor
package link_adaptor_pkg;

    // ********************
    // Bit timing
    // ********************
    // Reference clock rate and the two link rates, in MHz and Mbit/s
    localparam int unsigned REF_CLK_MHZ = 25;
    localparam int unsigned RATE_LO_MBPS = 10;
    localparam int unsigned RATE_HI_MBPS = 20;
    // Phase accumulator: step is the bit rate, modulus the clock rate
    localparam logic [5:0] ACC_MOD = 6'(REF_CLK_MHZ);
    localparam logic [5:0] ACC_INC_LO = 6'(RATE_LO_MBPS);
    localparam logic [5:0] ACC_INC_HI = 6'(RATE_HI_MBPS);
    localparam logic [5:0] ACC_HALF = ACC_MOD >> 1;

    // ********************
    // Framing
    // ********************
    localparam int unsigned DATA_BITS = 8;
    localparam logic [3:0] TX_DATA_LEN = 4'hb;  // start, one, 8 data, stop
    localparam logic [3:0] TX_ACK_LEN = 4'h2;   // start, zero
    localparam logic [10:0] TX_ACK_FRAME = 11'h001;
    localparam logic [3:0] RX_IDX_START = 4'h0;
    localparam logic [3:0] RX_IDX_KIND = 4'h1;
    localparam logic [3:0] RX_IDX_STOP = 4'ha;

    // ********************
    // Register selection
    // ********************
    localparam logic [1:0] SEL_DATA_IN = 2'h0;
    localparam logic [1:0] SEL_DATA_OUT = 2'h1;
    localparam logic [1:0] SEL_IN_STAT = 2'h2;
    localparam logic [1:0] SEL_OUT_STAT = 2'h3;
    localparam int unsigned STAT_READY_BIT = 0;
    localparam int unsigned STAT_IE_BIT = 1;
    localparam int unsigned TX_FIFO_DEPTH = 4;

endpackage

// file: core/byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [CW-1:0]    count_q;
    logic             push;
    logic             pop;

    // Honest flags straight from the occupancy count
    assign in_ready = (count_q != CW'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage, no reset needed on the data itself
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end

    a_fifo_bounds: assert property (@(posedge ref_clk) disable iff (reset)
        count_q <= CW'(DEPTH))
        else $error("fifo count beyond depth");

endmodule // byte_fifo
`default_nettype wire

// file: core/link_receiver.sv
// Oversampling receiver for data and acknowledge packets
`timescale 1ns/100ps
`default_nettype none
module link_receiver
    import link_adaptor_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Link side, already synchronised
    input  wire logic       rate_hi,
    input  wire logic       line,
    // Results
    output logic            byte_valid,
    output logic [7:0]      byte_data,
    output logic            ack_seen
);
    typedef enum logic {RX_IDLE, RX_RUN} rx_state_e;

    rx_state_e   state_q;
    logic [5:0]  acc_q;
    logic [5:0]  acc_sum;
    logic        tick;
    logic [5:0]  acc_inc;
    logic [5:0]  start_sum;
    logic        start_tick;
    logic [3:0]  idx_q;
    logic [7:0]  shift_q;

    // Fractional bit clock; the local clock is not a multiple of the bit rate
    assign acc_inc = rate_hi ? ACC_INC_HI : ACC_INC_LO;
    assign acc_sum = acc_q + acc_inc;
    assign tick = (acc_sum >= ACC_MOD);
    // Start is seen about half a clock after the real edge, so one step is
    // already owed; at the fast rate that step reaches mid start bit
    assign start_sum = ACC_HALF + acc_inc;
    assign start_tick = (start_sum >= ACC_MOD);

    // Start edge restarts the accumulator half a bit in, so samples
    // land mid-bit whatever the sender's clock phase
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= RX_IDLE;
            acc_q <= '0;
            idx_q <= '0;
            shift_q <= '0;
            byte_valid <= 1'b0;
            byte_data <= '0;
            ack_seen <= 1'b0;
        end else begin
            byte_valid <= 1'b0;
            ack_seen <= 1'b0;
            case (state_q)
                RX_IDLE: begin
                    if (line) begin
                        state_q <= RX_RUN;
                        acc_q <= start_tick ? start_sum - ACC_MOD : start_sum;
                        idx_q <= start_tick ? RX_IDX_KIND : RX_IDX_START;
                    end
                end
                RX_RUN: begin
                    acc_q <= tick ? acc_sum - ACC_MOD : acc_sum;
                    if (tick) begin
                        idx_q <= idx_q + 1'b1;
                        if (idx_q == RX_IDX_START) begin
                            // At the slow rate, a glitch shorter than half a bit is dropped
                            if (!line) state_q <= RX_IDLE;
                        end else if (idx_q == RX_IDX_KIND) begin
                            if (!line) begin
                                ack_seen <= 1'b1;
                                state_q <= RX_IDLE;
                            end
                        end else if (idx_q == RX_IDX_STOP) begin
                            // Framing error: byte is silently dropped
                            byte_valid <= !line;
                            byte_data <= shift_q;
                            state_q <= RX_IDLE;
                        end else begin
                            shift_q <= {line, shift_q[7:1]};
                        end
                    end
                end
                default: state_q <= RX_IDLE;
            endcase
        end
    end

    a_byte_needs_stop: assert property (@(posedge ref_clk) disable iff (reset)
        byte_valid |-> !$past(line) && $past(idx_q) == RX_IDX_STOP)
        else $error("byte accepted without low stop bit");

endmodule // link_receiver
`default_nettype wire

// file: core/link_adaptor.sv
// Serial link to byte-wide parallel bus adaptor, top level
`timescale 1ns/100ps
`default_nettype none

module link_adaptor
    import link_adaptor_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Serial link
    input  wire logic       rate_select,
    input  wire logic       serial_rx_line,
    output logic            serial_tx_line,
    // Parallel bus
    input  wire logic       chip_select_n,
    input  wire logic [1:0] reg_select,
    input  wire logic       read_write_line,
    input  wire logic [7:0] parallel_data_bus_in,
    output logic      [7:0] parallel_data_bus_out,
    output logic            parallel_data_bus_oe,
    // Interrupts
    output logic            rx_avail_irq,
    output logic            tx_empty_irq
);
    import link_adaptor_pkg::*;

    typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;

    localparam int unsigned PIN_W = 14;

    // ********************
    // Pin synchronisers
    // ********************
    logic [PIN_W-1:0] pin_meta_q;
    logic [PIN_W-1:0] pin_sync_q;
    logic             rx_s;
    logic             rate_s;
    logic             cs_n_s;
    logic [1:0]       sel_s;
    logic             rw_s;
    logic [7:0]       din_s;

    // Every pin crosses two flops before any logic looks at it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= {serial_rx_line, rate_select, ~chip_select_n,
                           reg_select, read_write_line, parallel_data_bus_in};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Chip select is carried inverted so reset reads as deselected
    logic cs_s;
    assign {rx_s, rate_s, cs_s, sel_s, rw_s, din_s} = pin_sync_q;
    assign cs_n_s = ~cs_s;

    // ********************
    // Bus cycle tracking
    // ********************
    logic       cs_n_prev_q;
    logic       cs_fall;
    logic       cs_rise;
    logic       active_q;
    logic       rd_q;
    logic [1:0] sel_q;
    logic [7:0] rd_data_q;
    logic       rx_full_q;
    logic [7:0] rx_byte_q;
    logic       ie_in_q;
    logic       ie_out_q;
    logic       fifo_in_ready;
    logic [7:0] stat_in;
    logic [7:0] stat_out;

    assign cs_fall = cs_n_prev_q && !cs_n_s;
    assign cs_rise = !cs_n_prev_q && cs_n_s;

    always_comb begin
        stat_in = '0;
        stat_in[STAT_READY_BIT] = rx_full_q;
        stat_in[STAT_IE_BIT] = ie_in_q;
        stat_out = '0;
        stat_out[STAT_READY_BIT] = fifo_in_ready;
        stat_out[STAT_IE_BIT] = ie_out_q;
    end

    // Select and direction freeze at the falling edge of chip select
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cs_n_prev_q <= 1'b1;
            active_q <= 1'b0;
            rd_q <= 1'b0;
            sel_q <= SEL_DATA_IN;
            rd_data_q <= '0;
        end else begin
            cs_n_prev_q <= cs_n_s;
            if (cs_fall) begin
                active_q <= 1'b1;
                sel_q <= sel_s;
                rd_q <= rw_s;
                case (sel_s)
                    SEL_DATA_IN:  rd_data_q <= rw_s ? rx_byte_q : '0;
                    SEL_IN_STAT:  rd_data_q <= stat_in;
                    SEL_OUT_STAT: rd_data_q <= stat_out;
                    default:      rd_data_q <= '0;
                endcase
            end else if (cs_rise) begin
                active_q <= 1'b0;
            end
        end
    end

    // Bus driven only in a selected read; floats during reset
    assign parallel_data_bus_oe = active_q && rd_q && !reset;
    assign parallel_data_bus_out = rd_data_q;

    // Write data is taken at the rising edge of chip select
    logic wr_commit;
    logic rd_commit;
    assign wr_commit = cs_rise && active_q && !rd_q;
    assign rd_commit = cs_rise && active_q && rd_q;

    // Interrupt enables, both off after reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ie_in_q <= 1'b0;
            ie_out_q <= 1'b0;
        end else if (wr_commit && sel_q == SEL_IN_STAT) begin
            ie_in_q <= din_s[STAT_IE_BIT];
        end else if (wr_commit && sel_q == SEL_OUT_STAT) begin
            ie_out_q <= din_s[STAT_IE_BIT];
        end
    end

    // ********************
    // Receive path
    // ********************
    logic       rx_byte_valid;
    logic [7:0] rx_byte_data;
    logic       rx_ack_seen;
    logic       ack_owed_q;
    logic       load_ack;

    link_receiver u_rx (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .rate_hi    (rate_s),
        .line       (rx_s),
        .byte_valid (rx_byte_valid),
        .byte_data  (rx_byte_data),
        .ack_seen   (rx_ack_seen)
    );

    // A new byte beats a read that ends in the same cycle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rx_full_q <= 1'b0;
            rx_byte_q <= '0;
        end else if (rx_byte_valid) begin
            rx_full_q <= 1'b1;
            rx_byte_q <= rx_byte_data;
        end else if (rd_commit && sel_q == SEL_DATA_IN) begin
            rx_full_q <= 1'b0;
        end
    end

    // One ack owed per byte; sent only once the holding register is free
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ack_owed_q <= 1'b0;
        end else if (rx_byte_valid) begin
            ack_owed_q <= 1'b1;
        end else if (load_ack) begin
            ack_owed_q <= 1'b0;
        end
    end

    assign rx_avail_irq = rx_full_q && ie_in_q && !reset;
    assign tx_empty_irq = fifo_in_ready && ie_out_q && !reset;

    // ********************
    // Transmit path
    // ********************
    logic       fifo_in_valid;
    logic       fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic       load_data;

    // Writes to a full queue are dropped; software polls the ready bit
    assign fifo_in_valid = wr_commit && sel_q == SEL_DATA_OUT;

    byte_fifo #(
        .WIDTH (DATA_BITS),
        .DEPTH (TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (din_s),
        .out_valid (fifo_out_valid),
        .out_ready (load_data),
        .out_data  (fifo_out_data)
    );

    tx_state_e   tx_state_q;
    logic [5:0]  tx_acc_q;
    logic [5:0]  tx_acc_sum;
    logic        tx_tick;
    logic [10:0] tx_shift_q;
    logic [3:0]  tx_left_q;
    logic        wait_ack_q;

    // Bit clock derived from the reference by a phase accumulator
    assign tx_acc_sum = tx_acc_q + (rate_s ? ACC_INC_HI : ACC_INC_LO);
    assign tx_tick = (tx_acc_sum >= ACC_MOD);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_acc_q <= '0;
        end else begin
            tx_acc_q <= tx_tick ? tx_acc_sum - ACC_MOD : tx_acc_sum;
        end
    end

    // Acks take priority over queued data; an ack still waits for a data frame already in flight
    assign load_ack = tx_tick && tx_state_q == TX_IDLE
                      && ack_owed_q && !rx_full_q;
    assign load_data = tx_tick && tx_state_q == TX_IDLE && !load_ack
                       && fifo_out_valid && !wait_ack_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_state_q <= TX_IDLE;
            tx_shift_q <= '0;
            tx_left_q <= '0;
        end else begin
            case (tx_state_q)
                TX_IDLE: begin
                    if (load_ack) begin
                        tx_shift_q <= TX_ACK_FRAME;
                        tx_left_q <= TX_ACK_LEN;
                        tx_state_q <= TX_SHIFT;
                    end else if (load_data) begin
                        tx_shift_q <= {1'b0, fifo_out_data, 2'b11};
                        tx_left_q <= TX_DATA_LEN;
                        tx_state_q <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (tx_tick) begin
                        tx_shift_q <= tx_shift_q >> 1;
                        tx_left_q <= tx_left_q - 1'b1;
                        if (tx_left_q == 4'h1) tx_state_q <= TX_IDLE;
                    end
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    // Only one data byte may be unacknowledged at a time
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wait_ack_q <= 1'b0;
        end else if (load_data) begin
            wait_ack_q <= 1'b1;
        end else if (rx_ack_seen) begin
            wait_ack_q <= 1'b0;
        end
    end

    // Line idles low and is forced low while in reset
    assign serial_tx_line = (tx_state_q == TX_SHIFT) && tx_shift_q[0]
                            && !reset;

    // ********************
    // Checks
    // ********************
    a_reset_quiet: assert property (@(posedge ref_clk)
        reset |-> !serial_tx_line && !rx_avail_irq && !tx_empty_irq)
        else $error("outputs not low during reset");

    a_reset_float: assert property (@(posedge ref_clk)
        reset |-> !parallel_data_bus_oe)
        else $error("data bus driven during reset");

    a_idle_low: assert property (@(posedge ref_clk) disable iff (reset)
        tx_state_q == TX_IDLE |-> !serial_tx_line)
        else $error("link output not low when idle");

    a_one_outstanding: assert property (@(posedge ref_clk) disable iff (reset)
        load_data |=> wait_ack_q && tx_state_q == TX_SHIFT)
        else $error("data frame started while awaiting ack");

    a_ack_after_free: assert property (@(posedge ref_clk) disable iff (reset)
        load_ack |-> !rx_full_q ##1 serial_tx_line)
        else $error("ack sent while holding register full");

    a_slow_rate: assert property (@(posedge ref_clk) disable iff (reset)
        (!rate_s && $stable(rate_s) && tx_tick) ##1 !rate_s |-> !tx_tick)
        else $error("bit ticks too close at low rate");

    a_fast_rate: assert property (@(posedge ref_clk) disable iff (reset)
        (rate_s && !tx_tick) ##1 rate_s |-> tx_tick)
        else $error("bit ticks too sparse at high rate");

    a_rx_irq_cause: assert property (@(posedge ref_clk) disable iff (reset)
        (rx_byte_valid && ie_in_q) |=> rx_avail_irq)
        else $error("receive interrupt missing after byte");

    a_read_pops: assert property (@(posedge ref_clk) disable iff (reset)
        (rd_commit && sel_q == SEL_DATA_IN && !rx_byte_valid) |=> !rx_full_q)
        else $error("data read did not release holding register");

    a_bad_write_ignored: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_commit && sel_q == SEL_DATA_IN) |=> $stable(ie_in_q) && $stable(ie_out_q))
        else $error("invalid write changed state");

endmodule // link_adaptor
`default_nettype wire

// file: dv/link_partner.sv
// Far-end link node model: decodes frames, acknowledges, sends data
`timescale 1ns/100ps
`default_nettype none
module link_partner (
    // Link
    input  wire logic rate_hi,
    input  wire logic tx_line,
    output var logic  rx_line
);
    // ********************
    // State seen by the bench
    // ********************
    logic    [7:0] got[$];
    int            acks = 0;
    int            errs = 0;
    bit            hold = 0;
    bit            busy = 0;
    logic    [7:0] b;
    realtime       bt;

    // Idle low, also throughout reset
    initial rx_line = 1'b0;
    always_comb bt = rate_hi ? 50.0 : 100.0;

    // One frame, LSB first; waits for the line to be free
    task automatic put(input logic [10:0] bits, input int n);
        wait (!busy);
        busy = 1;
        for (int i = 0; i < n; i++) begin
            rx_line = bits[i];
            #(bt);
        end
        rx_line = 1'b0;
        busy = 0;
    endtask

    task automatic send_data(input logic [7:0] d);
        put({1'b0, d, 2'b11}, 11);
    endtask

    // Mid-cell sampling; ack only when the bench lets go of hold
    always begin
        @(posedge tx_line);
        #(bt * 1.5);
        if (tx_line) begin
            for (int i = 0; i < 8; i++) begin
                #(bt);
                b[i] = tx_line;
            end
            #(bt);
            if (tx_line) errs++;
            got.push_back(b);
            fork
                begin
                    wait (!hold);
                    put(11'h001, 2);
                end
            join_none
        end else acks++;
    end
endmodule // link_partner
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the link adaptor top level
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import link_adaptor_pkg::*;
    // ********************
    // Signals
    // ********************
    logic       ref_clk = 1'b0;
    logic       reset = 1'b1;
    logic       rate_select = 1'b0;
    logic       chip_select_n = 1'b1;
    logic [1:0] reg_select = 2'h0;
    logic       read_write_line = 1'b1;
    logic [7:0] bus_in = 8'h00;
    logic [7:0] bus_out;
    logic [7:0] rd;
    logic       serial_rx_line;
    logic       serial_tx_line;
    logic       bus_oe;
    logic       rx_avail_irq;
    logic       tx_empty_irq;
    int         mismatches = 0;
    int         n_tests = 0;
    int         cycles = 0;

    link_adaptor i_dut (
        .ref_clk(ref_clk), .reset(reset), .rate_select(rate_select),
        .serial_rx_line(serial_rx_line), .serial_tx_line(serial_tx_line),
        .chip_select_n(chip_select_n), .reg_select(reg_select),
        .read_write_line(read_write_line), .parallel_data_bus_in(bus_in),
        .parallel_data_bus_out(bus_out), .parallel_data_bus_oe(bus_oe),
        .rx_avail_irq(rx_avail_irq), .tx_empty_irq(tx_empty_irq)
    );
    link_partner i_partner (
        .rate_hi(rate_select), .tx_line(serial_tx_line), .rx_line(serial_rx_line)
    );

    // 25 MHz clock
    initial forever #20 ref_clk = ~ref_clk;

    // Hang guard, well above the roughly one thousand cycles the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    // ********************
    // Shared tasks
    // ********************
    task automatic test_done();
        if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // Bus cycle; long holds cover the pin synchronisers
    task automatic bus(input logic [1:0] sel, input logic rw, input logic [7:0] d);
        @(posedge ref_clk);
        reg_select <= sel;
        read_write_line <= rw;
        bus_in <= d;
        repeat (3) @(posedge ref_clk);
        chip_select_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        check({7'h0, bus_oe}, {7'h0, rw});
        rd = bus_out;
        @(posedge ref_clk);
        chip_select_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        // Step off the edge so callers never race the design's updates
        #1;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic t_reset();
        // Power-on settling shrunk to a few cycles to keep runs short
        idle(8);
        check({6'h0, rx_avail_irq, tx_empty_irq}, 8'h00);
        check({7'h0, serial_tx_line}, 8'h00);
        check({7'h0, bus_oe}, 8'h00);
        @(posedge ref_clk);
        reset <= 1'b0;
        bus(SEL_IN_STAT, 1'b1, 8'h00);
        check(rd, 8'h00);
        bus(SEL_OUT_STAT, 1'b1, 8'h00);
        check(rd, 8'h01);
    endtask

    // Ack is withheld until the host drains the holding register
    task automatic t_rx();
        int n0;
        bus(SEL_IN_STAT, 1'b0, 8'h02);
        check({7'h0, rx_avail_irq}, 8'h00);
        i_partner.send_data(8'ha5);
        for (int i = 0; i < 100; i++) if (rx_avail_irq !== 1'b1) @(posedge ref_clk);
        check({7'h0, rx_avail_irq}, 8'h01);
        bus(SEL_IN_STAT, 1'b1, 8'h00);
        check(rd, 8'h03);
        n0 = i_partner.acks;
        idle(100);
        check(8'(i_partner.acks), 8'(n0));
        bus(SEL_DATA_IN, 1'b1, 8'h00);
        check(rd, 8'ha5);
        idle(100);
        check(8'(i_partner.acks), 8'(n0 + 1));
        check({7'h0, rx_avail_irq}, 8'h00);
        bus(SEL_DATA_OUT, 1'b1, 8'h00);
        check(rd, 8'h00);
        bus(SEL_DATA_IN, 1'b0, 8'h00);
        bus(SEL_IN_STAT, 1'b1, 8'h00);
        check(rd, 8'h02);
    endtask

    // Fill the queue with the far end stalling, then drain in order
    task automatic t_tx();
        int n;
        bus(SEL_OUT_STAT, 1'b0, 8'h02);
        check({7'h0, tx_empty_irq}, 8'h01);
        i_partner.hold = 1;
        n = 0;
        rd = 8'h01;
        while (rd[0] === 1'b1 && n < 8) begin
            bus(SEL_DATA_OUT, 1'b0, 8'(8'h10 + n));
            n++;
            bus(SEL_OUT_STAT, 1'b1, 8'h00);
        end
        check({7'h0, tx_empty_irq}, 8'h00);
        check({7'h0, n >= TX_FIFO_DEPTH}, 8'h01);
        bus(SEL_DATA_OUT, 1'b0, 8'hee);
        i_partner.hold = 0;
        for (int i = 0; i < 3000; i++) if (i_partner.got.size() < n) @(posedge ref_clk);
        idle(200);
        check(8'(i_partner.got.size()), 8'(n));
        for (int i = 0; i < n; i++) check(i_partner.got[i], 8'(8'h10 + i));
        check(8'(i_partner.errs), 8'h00);
        check({6'h0, serial_tx_line, tx_empty_irq}, 8'h01);
    endtask

    // Three high cells of byte 0x80 span 3..5 cycles at the fast rate
    task automatic t_rate();
        int highs;
        int n0;
        highs = 0;
        n0 = i_partner.got.size();
        @(posedge ref_clk);
        rate_select <= 1'b1;
        idle(10);
        // Count from the bus cycle on; the frame starts before it returns
        fork
            bus(SEL_DATA_OUT, 1'b0, 8'h80);
            for (int i = 0; i < 60; i++) begin
                @(posedge ref_clk);
                if (serial_tx_line === 1'b1) highs++;
            end
        join
        check({7'h0, highs >= 3 && highs <= 5}, 8'h01);
        idle(50);
        check(8'(i_partner.got.size()), 8'(n0 + 1));
        check(i_partner.got[n0], 8'h80);
    endtask

    // Main sequence
    initial begin
        t_reset();
        t_rx();
        t_tx();
        t_rate();
        test_done();
    end
endmodule // tb_top
`default_nettype wire
